// ### sssl_host_model.sv
// Host serial port model driving the data, clock, load and clear pins
`timescale 1ns/1ps
module sssl_host_model
    import sssl_pkg::*;
(
    // Bench clock
    input  wire logic           clock_in,
    // Host pins toward the block
    output sssl_pkg::sssl_pins_s pins_out
);
    import sssl_pkg::*;
    initial pins_out = '{1'b0, 1'b0, 1'b0, 1'b1};
    // Highest switch first, data steady over the whole pulse
    task automatic send(input sssl_word_t w);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clock_in) pins_out.host_serial_out <= w[i];
            repeat (3) @(posedge clock_in);
            pins_out.serial_clock <= 1'b1;
            repeat (9) @(posedge clock_in);
            pins_out.serial_clock <= 1'b0;
            repeat (9) @(posedge clock_in);
        end
        // Released data line shows the inverse, not the last bit
        pins_out.host_serial_out <= ~w[0];
    endtask
    // Load is raised only after a full byte
    task automatic pulse(input logic load_lvl, input logic clear_lvl_n);
        @(posedge clock_in) pins_out.latch_load <= load_lvl;
        pins_out.latch_clear_n <= clear_lvl_n;
        repeat (8) @(posedge clock_in);
        pins_out.latch_load <= 1'b0;
        pins_out.latch_clear_n <= 1'b1;
        repeat (8) @(posedge clock_in);
    endtask
endmodule

// ### sssl_pkg.sv
// Package for the serial switch select latch: widths, reset values, carrier types
package sssl_pkg;

    // ========================================================
    // Sizes and reset values
    localparam int          SSSL_CHANNELS    = 8;
    localparam logic [7:0]  SSSL_SHIFT_RESET = 8'h00;
    localparam logic [7:0]  SSSL_LATCH_RESET = 8'h00;
    localparam logic [1:0]  SSSL_SYNC_RESET  = 2'h0;
    // Clear pin idles high, so its synchroniser resets high
    localparam logic [1:0]  SSSL_CLR_SYNC_RESET = 2'h3;
    localparam logic        SSSL_EDGE_RESET  = 1'b0;

    // ========================================================
    // Carrier types
    typedef logic [SSSL_CHANNELS-1:0] sssl_word_t;

    // Host-side control pins, raw from the outside world
    typedef struct packed {
        logic host_serial_out;
        logic serial_clock;
        logic latch_load;
        logic latch_clear_n;
    } sssl_pins_s;

    // Load phases of the output latch
    typedef enum logic [1:0] {
        SSSL_HOLD,
        SSSL_LOAD,
        SSSL_CLEAR
    } sssl_latch_e;

endpackage

// ### sssl_switch_select.sv
// Serial-in shift register and output latch driving eight switch enables
//
// Operation
// - Each serial clock pulse shifts data in
// - Shift stages capture only on clock edges
// - Load high copies shift register to latch
// - Latch follows while loading, holds otherwise
// - Each latch bit enables one switch
// - Any switch combination may be on
// - Clear low forces latch to zeros
`timescale 1ns/1ps

module sssl_switch_select
    import sssl_pkg::*;
(
    // Clock and reset
    input  wire logic                 clock_in,
    input  wire logic                 reset_in,
    // Host pins, asynchronous to clock_in
    input  wire sssl_pkg::sssl_pins_s pins_in,
    // Switch enables, one per channel
    output logic [7:0]                switch_enable_out,
    // Shift register contents, for observation
    output logic [7:0]                shift_state_out
);
    import sssl_pkg::*;

    // ========================================================
    // Helper functions
    // One synchroniser step: stage one takes the pin, stage two stage one
    function automatic logic [1:0] sync_step(
        input logic [1:0] stages,
        input logic       pin
    );
        return {stages[0], pin};
    endfunction

    // One shift step: the new bit enters bit 0 and the others move up
    function automatic sssl_word_t shift_step(
        input sssl_word_t word,
        input logic       data_bit
    );
        return {word[SSSL_CHANNELS-2:0], data_bit};
    endfunction

    // Clear outranks load, so a clear with load held high still empties
    function automatic sssl_latch_e latch_mode_of(
        input logic clear_n,
        input logic load
    );
        if (!clear_n) begin
            return SSSL_CLEAR;
        end
        if (load) begin
            return SSSL_LOAD;
        end
        return SSSL_HOLD;
    endfunction

    // ========================================================
    // Data pin synchroniser
    // Logic reads stage two only; stage one may still be settling
    logic [1:0] data_sync_q;
    logic [1:0] data_sync_d;

    always_comb begin
        data_sync_d = sync_step(data_sync_q, pins_in.host_serial_out);
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            data_sync_q <= SSSL_SYNC_RESET;
        end else begin
            data_sync_q <= data_sync_d;
        end
    end

    // ========================================================
    // Serial clock pin synchroniser
    // Stage two feeds the edge detector; nothing reads stage one
    logic [1:0] clk_sync_q;
    logic [1:0] clk_sync_d;

    always_comb begin
        clk_sync_d = sync_step(clk_sync_q, pins_in.serial_clock);
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            clk_sync_q <= SSSL_SYNC_RESET;
        end else begin
            clk_sync_q <= clk_sync_d;
        end
    end

    // ========================================================
    // Load pin synchroniser
    // Load is a level: the latch stays open while it is high
    logic [1:0] load_sync_q;
    logic [1:0] load_sync_d;

    always_comb begin
        load_sync_d = sync_step(load_sync_q, pins_in.latch_load);
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            load_sync_q <= SSSL_SYNC_RESET;
        end else begin
            load_sync_q <= load_sync_d;
        end
    end

    // ========================================================
    // Clear pin synchroniser
    // Resets high, the idle level, so no clear follows reset
    logic [1:0] clear_sync_q;
    logic [1:0] clear_sync_d;

    always_comb begin
        clear_sync_d = sync_step(clear_sync_q, pins_in.latch_clear_n);
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            clear_sync_q <= SSSL_CLR_SYNC_RESET;
        end else begin
            clear_sync_q <= clear_sync_d;
        end
    end

    // ========================================================
    // Serial clock edge detector
    // Resets low, the idle level of the pin, so reset makes no false edge
    logic clk_prev_q;
    logic clk_prev_d;

    always_comb begin
        clk_prev_d = clk_sync_q[1];
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            clk_prev_q <= SSSL_EDGE_RESET;
        end else begin
            clk_prev_q <= clk_prev_d;
        end
    end

    // ========================================================
    // Synchronised pin levels
    logic serial_data;
    logic serial_rise;
    logic load_level;
    logic clear_level_n;

    assign serial_data   = data_sync_q[1];
    // Rising edge only; a held clock level shifts nothing
    assign serial_rise   = clk_sync_q[1] & ~clk_prev_q;
    assign load_level    = load_sync_q[1];
    assign clear_level_n = clear_sync_q[1];

    // ========================================================
    // Shift register
    // Data enters bit 0 and moves up, so the first bit ends in bit 7
    // A pin held high shifts once: serial_rise lasts one cycle
    sssl_word_t shift_q, shift_d;

    always_comb begin
        shift_d = shift_q;
        if (serial_rise) begin
            shift_d = shift_step(shift_q, serial_data);
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            shift_q <= SSSL_SHIFT_RESET;
        end else begin
            shift_q <= shift_d;
        end
    end

    // ========================================================
    // Output latch
    // Transparent latch modelled on the fast clock: while load is high it
    // tracks the shift register every cycle, so bits shifted during load
    // also pass through, as in the real part.
    sssl_latch_e latch_mode;
    sssl_word_t  latch_q, latch_d;

    // Mode decode kept apart so the priority sits in one place
    always_comb begin
        latch_mode = latch_mode_of(clear_level_n, load_level);
    end

    always_comb begin
        case (latch_mode)
            SSSL_CLEAR: latch_d = SSSL_LATCH_RESET;
            SSSL_LOAD:  latch_d = shift_q;
            SSSL_HOLD:  latch_d = latch_q;
            default:    latch_d = latch_q;
        endcase
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            latch_q <= SSSL_LATCH_RESET;
        end else begin
            latch_q <= latch_d;
        end
    end

    // ========================================================
    // Outputs
    // No one-hot decode: every pattern of enables is legal
    // Both outputs come straight from flops, so they never glitch
    assign switch_enable_out = latch_q;
    assign shift_state_out   = shift_q;

endmodule

// ### sssl_switch_select_sva.sv
// Checker for the serial switch select latch
`timescale 1ns/1ps
module sssl_switch_select_sva
    import sssl_pkg::*;
(
    input wire logic                 clock_in,
    input wire logic                 reset_in,
    input wire sssl_pkg::sssl_pins_s pins_in,
    input wire logic [7:0]           switch_enable_out,
    input wire logic [7:0]           shift_state_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    wire sssl_pins_s p = pins_in;
    wire [7:0] sw = switch_enable_out;
    wire [7:0] sh = shift_state_out;
    a_shift_in: assert property ($rose(p.serial_clock) ##1 p.serial_clock[*4] |->
        sh == {$past(sh[6:0], 4), $past(p.host_serial_out, 4)}) else $error("bad shift");
    a_no_level: assert property (p.serial_clock[*8] |-> $stable(sh)) else $error("level shift");
    a_shift_idle: assert property ((!p.serial_clock)[*8] |-> $stable(sh)) else $error("idle shift");
    a_clr_zero: assert property ((!p.latch_clear_n)[*4] |-> sw == 8'h00) else $error("no clear");
    a_clr_win: assert property ($fell(p.latch_clear_n) |-> ##[1:4] sw == 8'h00) else $error("slow clear");
    a_hold_sw: assert property ((!p.latch_load && p.latch_clear_n)[*5] |-> $stable(sw))
        else $error("enables moved");
    a_load_copy: assert property ((p.latch_load && p.latch_clear_n && !p.serial_clock)[*6]
        |-> sw == sh) else $error("load mismatch");
    a_load_stab: assert property ((p.latch_load && p.latch_clear_n && !p.serial_clock)[*7]
        |-> $stable(sw)) else $error("latch unstable");
endmodule
bind sssl_switch_select sssl_switch_select_sva i_sva (.clock_in(clock_in), .reset_in(reset_in),
    .pins_in(pins_in), .switch_enable_out(switch_enable_out), .shift_state_out(shift_state_out));

// ### tb_sssl_switch_select.sv
// Testbench for the serial switch select latch
`timescale 1ns/1ps
module tb_sssl_switch_select;
    import sssl_pkg::*;
    logic       clock_in, reset_in;
    sssl_pins_s pins;
    logic [7:0] sw, sh;
    int         err_count = 0, n_tests = 0;
    sssl_host_model i_host (.clock_in(clock_in), .pins_out(pins));
    sssl_switch_select i_dut (.clock_in(clock_in), .reset_in(reset_in), .pins_in(pins),
        .switch_enable_out(sw), .shift_state_out(sh));
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("%0d compares, %0d mismatches", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Shift a byte, load it, then shift its inverse without load
    task automatic t_load(input sssl_word_t w);
        i_host.send(w);
        #1 check(sh, w);
        i_host.pulse(1'b1, 1'b1);
        #1 check(sw, w);
        i_host.send(~w);
        #1 check(sw, w);
        $display("load %h done", w);
    endtask
    // Clear wins even with load held high
    task automatic t_clear(input logic load_lvl);
        i_host.pulse(load_lvl, 1'b0);
        #1 check(sw, 8'h00);
        $display("clear with load %b done", load_lvl);
    endtask
    initial begin
        reset_in = 1'b1;
        repeat (16) @(posedge clock_in);
        reset_in <= 1'b0;
        t_load(8'h80);
        t_load(8'hff);
        t_clear(1'b0);
        t_load(8'h5a);
        t_clear(1'b1);
        end_of_test();
    end
endmodule
